// ===== uncorrectable_error_status_pkg.sv
// package: offsets, field layouts and reset values of the error reporting registers
package uncorrectable_error_status_pkg;
  localparam logic [11:0] UNCORRECTABLE_ERROR_STATUS_CAP_OFFSET = 12'h100;
  localparam logic [11:0] UNCORRECTABLE_ERROR_STATUS_STATUS_OFFSET = 12'h104;
  localparam logic [11:0] UNCORRECTABLE_ERROR_STATUS_MASK_OFFSET = 12'h108;
  localparam logic [15:0] UNCORRECTABLE_ERROR_STATUS_CAP_ID = 16'h0001;
  localparam logic [3:0] UNCORRECTABLE_ERROR_STATUS_CAP_VERSION = 4'h1;
  localparam logic [11:0] UNCORRECTABLE_ERROR_STATUS_NEXT_LINK_RESET = 12'h000;
  localparam int UNCORRECTABLE_ERROR_STATUS_NEXT_LSB = 20;
  localparam int UNCORRECTABLE_ERROR_STATUS_VER_LSB = 16;
  localparam int UNCORRECTABLE_ERROR_STATUS_B_LEGACY = 0;
  localparam int UNCORRECTABLE_ERROR_STATUS_B_DLP = 4;
  localparam int UNCORRECTABLE_ERROR_STATUS_B_SDOWN = 5;
  localparam int UNCORRECTABLE_ERROR_STATUS_B_POISON = 12;
  localparam int UNCORRECTABLE_ERROR_STATUS_B_FCP = 13;
  localparam int UNCORRECTABLE_ERROR_STATUS_B_CTO = 14;
  localparam int UNCORRECTABLE_ERROR_STATUS_B_ABORT = 15;
  localparam int UNCORRECTABLE_ERROR_STATUS_B_UCOMP = 16;
  localparam int UNCORRECTABLE_ERROR_STATUS_B_ROVR = 17;
  localparam int UNCORRECTABLE_ERROR_STATUS_B_MALF = 18;
  localparam int UNCORRECTABLE_ERROR_STATUS_B_ECRC = 19;
  localparam int UNCORRECTABLE_ERROR_STATUS_B_UR = 20;
  localparam int UNCORRECTABLE_ERROR_STATUS_B_ACCESS = 21;
  localparam int UNCORRECTABLE_ERROR_STATUS_B_INTERNAL = 22;
  localparam int UNCORRECTABLE_ERROR_STATUS_B_MCBLK = 23;
  // bits that software may clear; hardware may set each of them except bit 0
  localparam logic [31:0] UNCORRECTABLE_ERROR_STATUS_STATUS_WMASK = 32'h00FF3031;
  localparam logic [31:0] UNCORRECTABLE_ERROR_STATUS_MASK_WMASK = 32'h00FF3031;
  localparam logic [31:0] UNCORRECTABLE_ERROR_STATUS_STATUS_RESET = 32'h00000000;
  localparam logic [31:0] UNCORRECTABLE_ERROR_STATUS_MASK_RESET = 32'h00000000;
endpackage

// ===== uncorrectable_error_status_evt_if.sv
// interface: error event strobes from the detectors into the status register
`timescale 1ns/1ps
interface uncorrectable_error_status_evt_if;
  logic [31:0] set_vec;
  logic [31:0] unmasked;
  modport src (output set_vec, input unmasked);
  modport dst (input set_vec, output unmasked);
endinterface

// ===== uncorrectable_error_status_collect.sv
// module: gathers detector strobes into one status set vector
`timescale 1ns/1ps
module uncorrectable_error_status_collect
  import uncorrectable_error_status_pkg::*;
(
  // detector strobes
  input wire logic link_protocol_error,
  input wire logic surprise_down_error,
  input wire logic surprise_down_reporting_capable,
  input wire logic poisoned_packet,
  input wire logic flow_control_error,
  input wire logic unexpected_completion_flag,
  input wire logic receive_overflow_flag,
  input wire logic malformed_packet,
  input wire logic ecrc_error,
  input wire logic unsupported_request,
  input wire logic access_control_violation,
  input wire logic internal_uncorrectable_error,
  input wire logic multicast_blocked_packet,
  // toward the status register
  uncorrectable_error_status_evt_if.src evt
);
  always_comb begin
    evt.set_vec = '0;
    evt.set_vec[UNCORRECTABLE_ERROR_STATUS_B_DLP] = link_protocol_error; // [RQ5]
    evt.set_vec[UNCORRECTABLE_ERROR_STATUS_B_SDOWN] = surprise_down_error & surprise_down_reporting_capable; // [RQ6]
    evt.set_vec[UNCORRECTABLE_ERROR_STATUS_B_POISON] = poisoned_packet; // [RQ7]
    evt.set_vec[UNCORRECTABLE_ERROR_STATUS_B_FCP] = flow_control_error; // [RQ8]
    evt.set_vec[UNCORRECTABLE_ERROR_STATUS_B_UCOMP] = unexpected_completion_flag; // [RQ11]
    evt.set_vec[UNCORRECTABLE_ERROR_STATUS_B_ROVR] = receive_overflow_flag; // [RQ12]
    evt.set_vec[UNCORRECTABLE_ERROR_STATUS_B_MALF] = malformed_packet; // [RQ13]
    evt.set_vec[UNCORRECTABLE_ERROR_STATUS_B_ECRC] = ecrc_error; // [RQ14]
    evt.set_vec[UNCORRECTABLE_ERROR_STATUS_B_UR] = unsupported_request; // [RQ15]
    // an abort caused by access control is logged here only, never as completer abort
    evt.set_vec[UNCORRECTABLE_ERROR_STATUS_B_ACCESS] = access_control_violation; // [RQ16] [RQ10]
    evt.set_vec[UNCORRECTABLE_ERROR_STATUS_B_INTERNAL] = internal_uncorrectable_error; // [RQ17]
    evt.set_vec[UNCORRECTABLE_ERROR_STATUS_B_MCBLK] = multicast_blocked_packet; // [RQ18]
  end
endmodule

// ===== uncorrectable_error_status_report.sv
// module: registers the unmasked error report pulses
`timescale 1ns/1ps
module uncorrectable_error_status_report
  import uncorrectable_error_status_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // mask and events
  input wire logic [31:0] mask,
  uncorrectable_error_status_evt_if.dst evt,
  // reporting
  output logic [31:0] report
);
  typedef struct packed {
    logic [31:0] report;
  } uncorrectable_error_status_rep_t;
  uncorrectable_error_status_rep_t st;
  uncorrectable_error_status_rep_t next_st;
  // masked errors still reach the status bit; only the report is withheld
  always_comb begin
    next_st.report = evt.set_vec & ~mask & UNCORRECTABLE_ERROR_STATUS_MASK_WMASK; // [RQ19]
    evt.unmasked = st.report;
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign report = st.report;
endmodule

// ===== uncorrectable_error_status_top.sv
// module: error reporting capability header, uncorrectable status and mask registers
`timescale 1ns/1ps
// What this block does
// RQ1 - header bits 15:0 read only, return capability identifier 0x1
// RQ2 - header bits 19:16 read only, return version 0x1
// RQ3 - next link bits 31:20 writable only while unlocked; zero ends chain
// RQ4 - status bit 0 sticky, write one clears, hardware never sets it
// RQ5 - status bit 4 set on data link protocol error
// RQ6 - status bit 5 set on surprise down only if reporting capable
// RQ7 - status bit 12 set on received poisoned packet
// RQ8 - status bit 13 set on flow control protocol violation
// RQ9 - status bit 14 completion timeout hardwired to zero
// RQ10 - status bit 15 never set; access aborts log as access violation
// RQ11 - status bit 16 set on unexpected completion
// RQ12 - status bit 17 set on receive buffer overflow
// RQ13 - status bit 18 set on malformed packet
// RQ14 - status bit 19 set on end-to-end crc failure
// RQ15 - status bit 20 set on unsupported request
// RQ16 - status bit 21 set on access-control violation
// RQ17 - status bit 22 set on internal uncorrectable error
// RQ18 - status bit 23 set on blocked multicast packet
// RQ19 - mask bit suppresses reporting but status bit still sets
// RQ20 - writing one clears, zero keeps; sticky bits survive non-power-on reset
// RQ21 - reserved status bits read zero, writes ignored
module uncorrectable_error_status_top
  import uncorrectable_error_status_pkg::*;
(
  // clock and resets
  input wire logic clk,
  input wire logic reset,
  input wire logic sticky_reset,
  // configuration access
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [11:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic cfg_write_lock,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  // detector strobes
  input wire logic link_protocol_error,
  input wire logic surprise_down_error,
  input wire logic surprise_down_reporting_capable,
  input wire logic poisoned_packet,
  input wire logic flow_control_error,
  input wire logic unexpected_completion_flag,
  input wire logic receive_overflow_flag,
  input wire logic malformed_packet,
  input wire logic ecrc_error,
  input wire logic unsupported_request,
  input wire logic access_control_violation,
  input wire logic internal_uncorrectable_error,
  input wire logic multicast_blocked_packet,
  // reporting
  output logic [31:0] error_report,
  output logic [31:0] uncorrectable_error_status
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [11:0] next_link;
    logic [31:0] rdata;
    logic rvalid;
  } uncorrectable_error_status_ctl_t;

  typedef struct packed {
    logic [31:0] status;
    logic [31:0] mask;
  } uncorrectable_error_status_sticky_t;

  uncorrectable_error_status_ctl_t st;
  uncorrectable_error_status_ctl_t next_st;
  uncorrectable_error_status_sticky_t sk;
  uncorrectable_error_status_sticky_t next_sk;
  uncorrectable_error_status_evt_if evt ();

  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  uncorrectable_error_status_collect u_collect (
    .link_protocol_error(link_protocol_error),
    .surprise_down_error(surprise_down_error),
    .surprise_down_reporting_capable(surprise_down_reporting_capable),
    .poisoned_packet(poisoned_packet),
    .flow_control_error(flow_control_error),
    .unexpected_completion_flag(unexpected_completion_flag),
    .receive_overflow_flag(receive_overflow_flag),
    .malformed_packet(malformed_packet),
    .ecrc_error(ecrc_error),
    .unsupported_request(unsupported_request),
    .access_control_violation(access_control_violation),
    .internal_uncorrectable_error(internal_uncorrectable_error),
    .multicast_blocked_packet(multicast_blocked_packet),
    .evt(evt.src)
  );

  uncorrectable_error_status_report u_report (
    .clk(clk),
    .reset(reset),
    .mask(sk.mask),
    .evt(evt.dst),
    .report(error_report)
  );

  // ---------------------------------------------------------------
  // register access
  // ---------------------------------------------------------------
  always_comb begin
    logic [31:0] wbits;
    logic [31:0] clr;
    wbits = cfg_wdata & be_mask(cfg_be);
    clr = '0;
    next_st = st;
    next_sk = sk;
    next_st.rvalid = cfg_rd;
    next_st.rdata = '0;
    if (cfg_wr && cfg_addr == UNCORRECTABLE_ERROR_STATUS_CAP_OFFSET && !cfg_write_lock) begin
      if (cfg_be[2]) begin
        next_st.next_link[3:0] = cfg_wdata[UNCORRECTABLE_ERROR_STATUS_NEXT_LSB +: 4]; // [RQ3]
      end
      if (cfg_be[3]) begin
        next_st.next_link[11:4] = cfg_wdata[UNCORRECTABLE_ERROR_STATUS_NEXT_LSB + 4 +: 8]; // [RQ3]
      end
    end
    if (cfg_wr && cfg_addr == UNCORRECTABLE_ERROR_STATUS_STATUS_OFFSET) begin
      // only ones clear; reserved and hardwired positions are outside the mask
      clr = wbits & UNCORRECTABLE_ERROR_STATUS_STATUS_WMASK; // [RQ20] [RQ21] [RQ4]
    end
    if (cfg_wr && cfg_addr == UNCORRECTABLE_ERROR_STATUS_MASK_OFFSET) begin
      next_sk.mask = (sk.mask & ~be_mask(cfg_be))
        | (wbits & UNCORRECTABLE_ERROR_STATUS_MASK_WMASK);
    end
    // a set arriving with its clear wins, so no event is lost
    next_sk.status = ((sk.status & ~clr) | evt.set_vec) & UNCORRECTABLE_ERROR_STATUS_STATUS_WMASK; // [RQ19] [RQ9]
    if (cfg_rd) begin
      unique case (cfg_addr)
        UNCORRECTABLE_ERROR_STATUS_CAP_OFFSET: begin
          next_st.rdata = {st.next_link, UNCORRECTABLE_ERROR_STATUS_CAP_VERSION, UNCORRECTABLE_ERROR_STATUS_CAP_ID}; // [RQ1] [RQ2]
        end
        UNCORRECTABLE_ERROR_STATUS_STATUS_OFFSET: begin
          next_st.rdata = sk.status & UNCORRECTABLE_ERROR_STATUS_STATUS_WMASK; // [RQ21] [RQ9] [RQ10]
        end
        UNCORRECTABLE_ERROR_STATUS_MASK_OFFSET: begin
          next_st.rdata = sk.mask;
        end
        default: begin
          next_st.rdata = '0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      st.next_link <= UNCORRECTABLE_ERROR_STATUS_NEXT_LINK_RESET;
      st.rdata <= '0;
      st.rvalid <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // sticky state follows only the power-on reset
  always_ff @(posedge clk) begin
    if (sticky_reset) begin
      sk.status <= UNCORRECTABLE_ERROR_STATUS_STATUS_RESET; // [RQ20]
      sk.mask <= UNCORRECTABLE_ERROR_STATUS_MASK_RESET;
    end else begin
      sk <= next_sk;
    end
  end

  assign cfg_rdata = st.rdata;
  assign cfg_rvalid = st.rvalid;
  assign uncorrectable_error_status = sk.status;
endmodule

// ===== uncorrectable_error_status_host.sv
// partner model: host software issuing configuration reads and writes
`timescale 1ns/1ps
module uncorrectable_error_status_host (
  // clock
  input wire logic clk,
  // configuration access
  output logic cfg_rd,
  output logic cfg_wr,
  output logic [11:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvalid
);
  initial begin
    cfg_rd = 1'b0;
    cfg_wr = 1'b0;
    cfg_addr = 12'hFFF;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
  end
  task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] dat);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= dat;
    @(posedge clk);
    cfg_wr <= 1'b0;
    // released data shows its inverse, so a stale value never looks valid
    cfg_wdata <= ~dat;
    #1;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] dat, output logic v);
    @(posedge clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge clk);
    cfg_rd <= 1'b0;
    #1;
    dat = cfg_rdata;
    v = cfg_rvalid;
  endtask
endmodule

// ===== uncorrectable_error_status_top_properties.sv
// checker: header, sticky status and report relations at the block's ports
`timescale 1ns/1ps
module uncorrectable_error_status_top_properties
  import uncorrectable_error_status_pkg::*;
(
  // clock and resets
  input wire logic clk,
  input wire logic reset,
  input wire logic sticky_reset,
  // configuration access
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [11:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  // detectors
  input wire logic link_protocol_error,
  input wire logic surprise_down_error,
  input wire logic surprise_down_reporting_capable,
  // reporting
  input wire logic [31:0] error_report,
  input wire logic [31:0] uncorrectable_error_status
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset || sticky_reset);
  logic clr4;
  assign clr4 = cfg_wr && cfg_addr == UNCORRECTABLE_ERROR_STATUS_STATUS_OFFSET && cfg_be[0] && cfg_wdata[4];
  a_header_fixed: assert property (cfg_rd && cfg_addr == UNCORRECTABLE_ERROR_STATUS_CAP_OFFSET |=>
    cfg_rdata[19:0] == 20'h10001) else $error("header id or version wrong");
  a_reserved_zero: assert property (
    (uncorrectable_error_status & ~UNCORRECTABLE_ERROR_STATUS_STATUS_WMASK) == 32'h0) else $error("reserved bit set");
  a_legacy_stays_clear: assert property (!uncorrectable_error_status[0] |=>
    !uncorrectable_error_status[0]) else $error("legacy bit set");
  a_link_error_sets: assert property (link_protocol_error |=>
    uncorrectable_error_status[4]) else $error("link error not logged");
  a_sdown_sets: assert property (surprise_down_error && surprise_down_reporting_capable |=>
    uncorrectable_error_status[5]) else $error("surprise down not logged");
  a_sdown_gated: assert property (
    !uncorrectable_error_status[5] && !surprise_down_reporting_capable |=>
    !uncorrectable_error_status[5]) else $error("surprise down logged while incapable");
  a_one_clears: assert property (clr4 && !link_protocol_error |=>
    !uncorrectable_error_status[4]) else $error("write one did not clear");
  a_zero_keeps: assert property (uncorrectable_error_status[4] && !clr4 |=>
    uncorrectable_error_status[4]) else $error("status bit lost");
  a_report_logged: assert property (error_report != 32'h0 |->
    (error_report & ~uncorrectable_error_status) == 32'h0) else $error("report without status");
  c_read_header: cover property (cfg_rd && cfg_addr == UNCORRECTABLE_ERROR_STATUS_CAP_OFFSET);
  c_report: cover property (error_report != 32'h0);
  c_clear: cover property (clr4 ##1 !uncorrectable_error_status[4]);
endmodule
bind uncorrectable_error_status_top uncorrectable_error_status_top_properties uncorrectable_error_status_top_properties_inst (.clk(clk), .reset(reset),
  .sticky_reset(sticky_reset), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
  .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
  .link_protocol_error(link_protocol_error), .surprise_down_error(surprise_down_error),
  .surprise_down_reporting_capable(surprise_down_reporting_capable),
  .error_report(error_report), .uncorrectable_error_status(uncorrectable_error_status));

// ===== tb_top.sv
// testbench: event table, then register access and reset cases
`timescale 1ns/1ps
module tb_top;
  import uncorrectable_error_status_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic sticky_reset = 1'b1;
  logic lock = 1'b0;
  logic cap = 1'b1;
  logic [11:0] det = 12'h000;
  logic cfg_rd, cfg_wr, cfg_rvalid, v;
  logic [11:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, rep, sts, d, s;
  int n_mismatch = 0;
  int n_compared = 0;
  // detector index beside the status bit it must set
  int rows [12][2] = '{'{0, 4}, '{1, 5}, '{2, 12}, '{3, 13}, '{4, 16}, '{5, 17}, '{6, 18},
    '{7, 19}, '{8, 20}, '{9, 21}, '{10, 22}, '{11, 23}};
  always #4 clk = ~clk;
  uncorrectable_error_status_host uncorrectable_error_status_host_inst (.clk(clk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid));
  uncorrectable_error_status_top uncorrectable_error_status_top_inst (.clk(clk), .reset(reset), .sticky_reset(sticky_reset),
    .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_write_lock(lock), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .link_protocol_error(det[0]), .surprise_down_error(det[1]),
    .surprise_down_reporting_capable(cap), .poisoned_packet(det[2]),
    .flow_control_error(det[3]), .unexpected_completion_flag(det[4]),
    .receive_overflow_flag(det[5]), .malformed_packet(det[6]), .ecrc_error(det[7]),
    .unsupported_request(det[8]), .access_control_violation(det[9]),
    .internal_uncorrectable_error(det[10]), .multicast_blocked_packet(det[11]),
    .error_report(rep), .uncorrectable_error_status(sts));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    uncorrectable_error_status_host_inst.rd(a, d, v);
    chk("rvalid", 32'h1, {31'h0, v});
    chk("rdata", e, d);
  endtask
  task automatic pulse(input int k);
    @(posedge clk);
    det[k] <= 1'b1;
    @(posedge clk);
    det[k] <= 1'b0;
    #1;
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // the whole run needs about a hundred cycles
  initial begin
    #(8 * 3000);
    n_mismatch++;
    results();
  end
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    sticky_reset <= 1'b0;
    rdchk(UNCORRECTABLE_ERROR_STATUS_STATUS_OFFSET, 32'h0);
    rdchk(UNCORRECTABLE_ERROR_STATUS_CAP_OFFSET, 32'h00010001);
    foreach (rows[i]) begin
      s = 32'h1 << rows[i][1];
      pulse(rows[i][0]);
      chk("status", s, sts);
      chk("report", s, rep);
      uncorrectable_error_status_host_inst.wr(UNCORRECTABLE_ERROR_STATUS_STATUS_OFFSET, 4'hF, s);
      chk("cleared", 32'h0, sts);
    end
    @(posedge clk);
    lock <= 1'b1;
    uncorrectable_error_status_host_inst.wr(UNCORRECTABLE_ERROR_STATUS_CAP_OFFSET, 4'hF, 32'hFFFFFFFF);
    rdchk(UNCORRECTABLE_ERROR_STATUS_CAP_OFFSET, 32'h00010001);
    @(posedge clk);
    lock <= 1'b0;
    uncorrectable_error_status_host_inst.wr(UNCORRECTABLE_ERROR_STATUS_CAP_OFFSET, 4'hF, 32'hFFFFFFFF);
    rdchk(UNCORRECTABLE_ERROR_STATUS_CAP_OFFSET, 32'hFFF10001);
    @(posedge clk);
    cap <= 1'b0;
    pulse(1);
    chk("sdown", 32'h0, sts);
    pulse(2);
    uncorrectable_error_status_host_inst.wr(UNCORRECTABLE_ERROR_STATUS_STATUS_OFFSET, 4'hF, 32'hFFFFEFFF);
    uncorrectable_error_status_host_inst.wr(UNCORRECTABLE_ERROR_STATUS_STATUS_OFFSET, 4'hD, 32'h00001000);
    rdchk(UNCORRECTABLE_ERROR_STATUS_STATUS_OFFSET, 32'h00001000);
    uncorrectable_error_status_host_inst.wr(UNCORRECTABLE_ERROR_STATUS_STATUS_OFFSET, 4'h2, 32'h00001000);
    uncorrectable_error_status_host_inst.wr(UNCORRECTABLE_ERROR_STATUS_MASK_OFFSET, 4'hF, 32'h00000010);
    pulse(0);
    chk("masked", 32'h10, sts);
    chk("mreport", 32'h0, rep);
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk("sticky", 32'h10, sts);
    rdchk(UNCORRECTABLE_ERROR_STATUS_CAP_OFFSET, 32'h00010001);
    rdchk(UNCORRECTABLE_ERROR_STATUS_MASK_OFFSET, 32'h00000010);
    @(posedge clk);
    sticky_reset <= 1'b1;
    @(posedge clk);
    sticky_reset <= 1'b0;
    #1;
    chk("por", 32'h0, sts);
    rdchk(12'h10C, 32'h0);
    // an event and its write-one clear in the same cycle: the event must win
    fork
      pulse(3);
      uncorrectable_error_status_host_inst.wr(UNCORRECTABLE_ERROR_STATUS_STATUS_OFFSET, 4'hF, 32'h00002000);
    join
    chk("setwins", 32'h2000, sts);
    chk("wreport", 32'h2000, rep);
    results();
  end
endmodule
